// ==== pfmr_pkg.sv ====
package pfmr_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_EVENT_LATCH1 = 8'h20;
   localparam logic [7:0] ADDR_EVENT_LATCH2 = 8'h21;
   localparam logic [7:0] ADDR_POWER_SENSE = 8'h22;
   localparam logic [7:0] ADDR_FAULT_SENSE = 8'h23;
   localparam logic [7:0] ADDR_POWER_CLOCK_MASK = 8'h24;
   localparam logic [7:0] ADDR_FAULT_MASK = 8'h25;
   localparam logic [7:0] ADDR_RESET_CONTROL = 8'h30;
   localparam logic [7:0] ADDR_PRODUCT_CODE = 8'h31;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_MASK = 8'hff;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [1:0] RST_POLICY = 2'h0;
   localparam logic RST_DEFAULTS_FLAG = 1'b1;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int POS_MASK_SPARE = 5;
   localparam int POS_DEFAULTS_FLAG = 4;
   localparam int POS_FORCE_RELOAD = 7;
   localparam int POS_THERMAL_SHUTDOWN = 7;
   // ----------------------------------------------------------------
   // thermal recovery policy codes
   // ----------------------------------------------------------------
   localparam logic [1:0] POLICY_RELOAD_RESTART = 2'h0;
   localparam logic [1:0] POLICY_KEEP_RESTART = 2'h1;
   localparam logic [1:0] POLICY_STAY_OFF = 2'h2;
   // ----------------------------------------------------------------
   // identity and bus address
   // ----------------------------------------------------------------
   // arbitrary value, not a real product code
   localparam logic [7:0] PRODUCT_CODE = 8'h5a;
   // arbitrary default target address for the serial bus
   localparam logic [6:0] BUS_ADDRESS = 7'h10;
   // ----------------------------------------------------------------
   // serial engine states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ,
      ST_READ_ACK
   } pfmr_state_type;
endpackage

// ==== pfmr_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// R1 - fault sense bits 0-4: live overcurrent flags
// R2 - fault sense bit 5: input undervoltage live
// R3 - fault sense bit 6: thermal warning live
// R4 - fault sense bit 7: thermal shutdown live
// R5 - mask bit 0 enables, 1 blocks source
// R6 - mask1 bits 0-4 power good, bit5 reads 1
// R7 - mask1 bit6 clock detect, bit7 clock select
// R8 - mask2 holds overcurrent, undervoltage, thermal masks
// R9 - policy 00: reload defaults, then restart
// R10 - policy 01: restart keeping register values
// R11 - policy 10 stays off; 11 undefined
// R12 - defaults flag set on reload, host clears
// R13 - force reload bit restores all defaults
// R14 - fixed read-only product code register
// R15 - events latch per source, cleared by read
// R16 - power sense reports live power good
// R17 - interrupt while unmasked latched event pending
// R18 - read-only registers ignore writes, spares fixed
module pfmr_regs
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // live analog indications, asynchronous
   input wire logic [4:0] power_good_live,
   input wire logic ext_clock_ok_live,
   input wire logic clock_select_live,
   input wire logic [4:0] overcurrent_live,
   input wire logic input_undervoltage_live,
   input wire logic thermal_warning_live,
   input wire logic thermal_shutdown_live,
   // system outputs
   output logic irq,
   output logic powerup_start,
   output logic defaults_reload,
   output logic rearm_blocked
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [7:0] power_meta, power_sense, power_prev;
   logic [7:0] fault_meta, fault_sense_live, fault_prev;
   logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
   // spare bit 5 of the power sense stays 0
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power_meta <= 8'h00;
         power_sense <= 8'h00;
         power_prev <= 8'h00;
         fault_meta <= 8'h00;
         fault_sense_live <= 8'h00;
         fault_prev <= 8'h00;
         scl_meta <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_meta <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         power_meta <= {clock_select_live, ext_clock_ok_live, 1'b0,
                        power_good_live};
         power_sense <= power_meta; // R16
         power_prev <= power_sense;
         fault_meta <= {thermal_shutdown_live, thermal_warning_live,
                        input_undervoltage_live, overcurrent_live};
         fault_sense_live <= fault_meta; // R1 R2 R3 R4
         fault_prev <= fault_sense_live;
         scl_meta <= scl_in;
         scl_s <= scl_meta;
         scl_d <= scl_s;
         sda_meta <= sda_in;
         sda_s <= sda_meta;
         sda_d <= sda_s;
      end
   end

   // ----------------------------------------------------------------
   // serial bus engine
   // ----------------------------------------------------------------
   pfmr_pkg::pfmr_state_type state;
   logic [7:0] shift, tx, ptr;
   logic [3:0] bit_cnt;
   logic rnw, first, nack;
   logic scl_rise, scl_fall, bus_start, bus_stop, load_now, wr_now;
   logic [7:0] rd_value;
   // start and stop are sda edges while scl is high
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
   // a read byte is fetched, and its side effects fire, on this edge
   assign load_now = scl_fall & ~bus_start & ~bus_stop &
                     ((state == pfmr_pkg::ST_ADDR_ACK && rnw) ||
                      (state == pfmr_pkg::ST_READ_ACK && !nack));
   assign wr_now = scl_fall && state == pfmr_pkg::ST_WRITE &&
                   bit_cnt == 4'h8 && !first;
   assign rd_value = reg_value(ptr);

   // byte framing; pointer auto-increments after every data byte
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= pfmr_pkg::ST_IDLE;
         shift <= 8'h00;
         tx <= 8'h00;
         ptr <= 8'h00;
         bit_cnt <= 4'h0;
         rnw <= 1'b0;
         first <= 1'b0;
         nack <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (bus_start)
      begin
         state <= pfmr_pkg::ST_ADDR;
         bit_cnt <= 4'h0;
         first <= 1'b1;
         sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
         state <= pfmr_pkg::ST_IDLE;
         sda_oe <= 1'b0;
      end
      else if (load_now)
      begin
         state <= pfmr_pkg::ST_READ;
         tx <= rd_value;
         sda_oe <= ~rd_value[7];
         bit_cnt <= 4'h1;
         ptr <= ptr + 8'h01;
      end
      else
      begin
         case (state)
            pfmr_pkg::ST_ADDR, pfmr_pkg::ST_WRITE:
            begin
               if (scl_rise)
               begin
                  shift <= {shift[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == 4'h8)
               begin
                  bit_cnt <= 4'h0;
                  if (state == pfmr_pkg::ST_WRITE)
                  begin
                     state <= pfmr_pkg::ST_WRITE_ACK;
                     sda_oe <= 1'b1;
                     first <= 1'b0;
                     ptr <= first ? shift : ptr + 8'h01;
                  end
                  else if (shift[7:1] == pfmr_pkg::BUS_ADDRESS)
                  begin
                     state <= pfmr_pkg::ST_ADDR_ACK;
                     rnw <= shift[0];
                     sda_oe <= 1'b1;
                  end
                  else
                     state <= pfmr_pkg::ST_IDLE;
               end
            end
            pfmr_pkg::ST_ADDR_ACK, pfmr_pkg::ST_WRITE_ACK:
            begin
               if (scl_fall)
               begin
                  state <= pfmr_pkg::ST_WRITE;
                  sda_oe <= 1'b0;
               end
            end
            pfmr_pkg::ST_READ:
            begin
               if (scl_fall && bit_cnt == 4'h8)
               begin
                  state <= pfmr_pkg::ST_READ_ACK;
                  sda_oe <= 1'b0;
               end
               else if (scl_fall)
               begin
                  tx <= {tx[6:0], 1'b0};
                  sda_oe <= ~tx[6];
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            pfmr_pkg::ST_READ_ACK:
            begin
               if (scl_rise)
                  nack <= sda_s;
               else if (scl_fall)
                  state <= pfmr_pkg::ST_IDLE;
            end
            default:
               state <= pfmr_pkg::ST_IDLE;
         endcase
      end
   end

   // pin is open drain: only ever pulled low
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0;
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [7:0] power_clock_irq_mask, fault_irq_mask;
   logic [7:0] power_clock_latched, fault_latched;
   logic [1:0] thermal_recovery_policy;
   logic defaults_loaded_flag, soft_reload, force_write, thermal_exit;
   logic [7:0] power_event, fault_event, pending_lo, pending_hi;

   // unmapped offsets read as zero; spare bits forced
   function automatic logic [7:0] reg_value(input logic [7:0] a);
      case (a)
         pfmr_pkg::ADDR_EVENT_LATCH1: reg_value = power_clock_latched;
         pfmr_pkg::ADDR_EVENT_LATCH2: reg_value = fault_latched;
         pfmr_pkg::ADDR_POWER_SENSE: reg_value = power_sense;
         pfmr_pkg::ADDR_FAULT_SENSE: reg_value = fault_sense_live;
         pfmr_pkg::ADDR_POWER_CLOCK_MASK: reg_value = power_clock_irq_mask;
         pfmr_pkg::ADDR_FAULT_MASK: reg_value = fault_irq_mask;
         pfmr_pkg::ADDR_RESET_CONTROL:
            reg_value = {3'h0, defaults_loaded_flag, 2'h0,
                         thermal_recovery_policy};
         pfmr_pkg::ADDR_PRODUCT_CODE:
            reg_value = pfmr_pkg::PRODUCT_CODE; // R14
         default: reg_value = 8'h00;
      endcase
   endfunction

   // power good and clock sources flag either edge, faults only onset
   assign power_event = (power_sense ^ power_prev) & 8'hdf;
   assign fault_event = fault_sense_live & ~fault_prev;
   assign force_write = wr_now && ptr == pfmr_pkg::ADDR_RESET_CONTROL &&
                        shift[pfmr_pkg::POS_FORCE_RELOAD];
   assign thermal_exit =
      fault_prev[pfmr_pkg::POS_THERMAL_SHUTDOWN] &
      ~fault_sense_live[pfmr_pkg::POS_THERMAL_SHUTDOWN];
   assign soft_reload = force_write || (thermal_exit && // R13
      thermal_recovery_policy == pfmr_pkg::POLICY_RELOAD_RESTART); // R9
   assign pending_lo = power_clock_latched & ~power_clock_irq_mask; // R5
   assign pending_hi = fault_latched & ~fault_irq_mask; // R5

   // writable registers; sense and product code take no write
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power_clock_irq_mask <= pfmr_pkg::RST_MASK;
         fault_irq_mask <= pfmr_pkg::RST_MASK;
         thermal_recovery_policy <= pfmr_pkg::RST_POLICY;
         defaults_loaded_flag <= pfmr_pkg::RST_DEFAULTS_FLAG;
      end
      else if (soft_reload)
      begin
         power_clock_irq_mask <= pfmr_pkg::RST_MASK; // R13
         fault_irq_mask <= pfmr_pkg::RST_MASK;
         thermal_recovery_policy <= pfmr_pkg::RST_POLICY;
         defaults_loaded_flag <= pfmr_pkg::RST_DEFAULTS_FLAG; // R12
      end
      else if (wr_now)
      begin
         case (ptr) // R18
            pfmr_pkg::ADDR_POWER_CLOCK_MASK:
               power_clock_irq_mask <= shift | 8'h20; // R6 R7
            pfmr_pkg::ADDR_FAULT_MASK:
               fault_irq_mask <= shift; // R8
            pfmr_pkg::ADDR_RESET_CONTROL:
            begin
               thermal_recovery_policy <= shift[1:0];
               defaults_loaded_flag <= shift[pfmr_pkg::POS_DEFAULTS_FLAG];
            end
            default:
               ;
         endcase
      end
   end

   // event latches: a new event beats a read clear in the same cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power_clock_latched <= pfmr_pkg::RST_LATCH;
         fault_latched <= pfmr_pkg::RST_LATCH;
      end
      else
      begin
         power_clock_latched <= (soft_reload ||
            (load_now && ptr == pfmr_pkg::ADDR_EVENT_LATCH1) ?
            8'h00 : power_clock_latched) | power_event; // R15
         fault_latched <= (soft_reload ||
            (load_now && ptr == pfmr_pkg::ADDR_EVENT_LATCH2) ?
            8'h00 : fault_latched) | fault_event; // R15
      end
   end

   // ----------------------------------------------------------------
   // interrupt and thermal recovery
   // ----------------------------------------------------------------
   // code 11 has no function, so it is held off like 10 for safety
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq <= 1'b0;
         powerup_start <= 1'b0;
         defaults_reload <= 1'b0;
         rearm_blocked <= 1'b0;
      end
      else
      begin
         irq <= |{pending_lo, pending_hi}; // R17
         defaults_reload <= soft_reload;
         powerup_start <= thermal_exit &&
            !thermal_recovery_policy[1]; // R9 R10
         if (thermal_exit && thermal_recovery_policy[1])
            rearm_blocked <= 1'b1; // R11
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_oc_live;
      fault_sense_live[4:0] == $past(overcurrent_live, 2);
   endproperty
   a_oc_live: assert property (p_oc_live) // R1
      else $error("overcurrent sense mismatch");
   property p_uv_live;
      fault_sense_live[5] == $past(input_undervoltage_live, 2);
   endproperty
   a_uv_live: assert property (p_uv_live) // R2
      else $error("undervoltage sense mismatch");
   property p_tw_live;
      fault_sense_live[6] == $past(thermal_warning_live, 2);
   endproperty
   a_tw_live: assert property (p_tw_live) // R3
      else $error("thermal warning sense mismatch");
   property p_tsd_live;
      fault_sense_live[7] == $past(thermal_shutdown_live, 2);
   endproperty
   a_tsd_live: assert property (p_tsd_live) // R4
      else $error("thermal shutdown sense mismatch");
   property p_all_masked;
      (&power_clock_irq_mask && &fault_irq_mask) |=> !irq;
   endproperty
   a_all_masked: assert property (p_all_masked) // R5
      else $error("masked source raised interrupt");
   property p_spare_one;
      power_clock_irq_mask[pfmr_pkg::POS_MASK_SPARE];
   endproperty
   a_spare_one: assert property (p_spare_one) // R6
      else $error("mask spare bit not one");
   property p_latch_tsd;
      $rose(fault_sense_live[7]) |=> fault_latched[7];
   endproperty
   a_latch_tsd: assert property (p_latch_tsd) // R15
      else $error("shutdown event not latched");
   property p_force;
      force_write |=> power_clock_irq_mask == pfmr_pkg::RST_MASK &&
         fault_irq_mask == pfmr_pkg::RST_MASK && defaults_loaded_flag;
   endproperty
   a_force: assert property (p_force) // R13
      else $error("force reload did not restore defaults");
   property p_keep;
      (thermal_exit && !force_write &&
       thermal_recovery_policy == pfmr_pkg::POLICY_KEEP_RESTART)
      |=> powerup_start && $stable(fault_irq_mask) && !defaults_reload;
   endproperty
   a_keep: assert property (p_keep) // R10
      else $error("keep policy restart wrong");
   property p_reload;
      (thermal_exit &&
       thermal_recovery_policy == pfmr_pkg::POLICY_RELOAD_RESTART)
      |=> powerup_start && defaults_reload && defaults_loaded_flag;
   endproperty
   a_reload: assert property (p_reload) // R9 R12
      else $error("reload policy restart wrong");
   property p_stay_off;
      (thermal_exit &&
       thermal_recovery_policy == pfmr_pkg::POLICY_STAY_OFF)
      |=> !powerup_start && rearm_blocked;
   endproperty
   a_stay_off: assert property (p_stay_off) // R11
      else $error("stay off policy restarted");
   property p_irq;
      irq |-> $past(|{pending_lo, pending_hi});
   endproperty
   a_irq: assert property (p_irq) // R17
      else $error("interrupt without pending event");
   c_force: cover property (force_write ##1 defaults_loaded_flag);
   c_irq: cover property ($rose(irq));
   c_restart: cover property (thermal_exit ##1 powerup_start);
   c_read: cover property (load_now ##[1:40] state == pfmr_pkg::ST_IDLE);
endmodule

// ==== pfmr_host.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// serial bus controller model on the host side
// ---------------------------------------------------------------
module pfmr_host
(
   // clock
   input wire logic clock,
   // device pull-down on the data line
   input wire logic sda_oe,
   // wire levels seen by the device
   output logic scl,
   output logic sda
);
   logic host_low;
   // open-drain data wire with pull-up: low when either party pulls
   assign sda = ~(host_low | sda_oe);
   initial
   begin
      scl = 1'b1;
      host_low = 1'b0;
   end
   // one bus clock phase, longer than the device's sync depth
   task automatic half();
      repeat (5) @(negedge clock);
   endtask
   // start, also a repeated start from a low clock phase
   task automatic start();
      host_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      host_low = 1'b1;
      half();
      scl = 1'b0;
      half();
   endtask
   task automatic stop();
      host_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      host_low = 1'b0;
      half();
   endtask
   // data moves a phase after the clock fall, never with it
   task automatic bit_io(input logic b, output logic seen);
      host_low = ~b;
      half();
      scl = 1'b1;
      half();
      seen = sda;
      half();
      scl = 1'b0;
      half();
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   // last byte of a read gets a refusal so the device lets go
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, s);
         d = {d[6:0], s};
      end
      bit_io(last, s);
   endtask
   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d,
                            output logic ack);
      logic a1, a2, a3;
      start();
      send_byte({pfmr_pkg::BUS_ADDRESS, 1'b0}, a1);
      send_byte(ptr, a2);
      send_byte(d, a3);
      stop();
      ack = a1 & a2 & a3;
   endtask
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d,
                           output logic ack);
      logic a1, a2, a3;
      start();
      send_byte({pfmr_pkg::BUS_ADDRESS, 1'b0}, a1);
      send_byte(ptr, a2);
      start();
      send_byte({pfmr_pkg::BUS_ADDRESS, 1'b1}, a3);
      get_byte(1'b1, d);
      stop();
      ack = a1 & a2 & a3;
   endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic clock, rst_n, scl, sda, sda_oe;
   logic [4:0] power_good_live, overcurrent_live;
   logic ext_clock_ok_live, clock_select_live, input_undervoltage_live;
   logic thermal_warning_live, thermal_shutdown_live;
   logic irq, powerup_start, defaults_reload, rearm_blocked;
   logic [7:0] rd;
   logic ack;
   int fails, checked, n_reload, n_start;
   logic [7:0] pats [4] = '{8'h15, 8'h6a, 8'h95, 8'h00};
   // ---------------------------------------------------------------
   // clock, device and host
   // ---------------------------------------------------------------
   initial clock = 1'b0;
   always #2.5 clock = ~clock;
   pfmr_regs uut (.clock(clock), .rst_n(rst_n), .scl_in(scl),
      .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .power_good_live(power_good_live),
      .ext_clock_ok_live(ext_clock_ok_live),
      .clock_select_live(clock_select_live),
      .overcurrent_live(overcurrent_live),
      .input_undervoltage_live(input_undervoltage_live),
      .thermal_warning_live(thermal_warning_live),
      .thermal_shutdown_live(thermal_shutdown_live), .irq(irq),
      .powerup_start(powerup_start), .defaults_reload(defaults_reload),
      .rearm_blocked(rearm_blocked));
   pfmr_host host (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   // pulses last one cycle, so they are counted rather than sampled
   always @(posedge clock)
   begin
      if (defaults_reload === 1'b1) n_reload++;
      if (powerup_start === 1'b1) n_start++;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] ptr, logic [7:0] d);
      host.write_reg(ptr, d, ack);
      check("write ack", {7'h00, ack}, 8'h01);
   endtask
   task automatic rd_chk(logic [7:0] ptr, logic [7:0] exp, string name);
      host.read_reg(ptr, rd, ack);
      check("read ack", {7'h00, ack}, 8'h01);
      check(name, rd, exp);
   endtask
   // fault inputs change at the falling edge, then settle past sync
   task automatic set_sense(logic [7:0] v);
      @(negedge clock);
      {thermal_shutdown_live, thermal_warning_live, input_undervoltage_live,
       overcurrent_live} = v;
      repeat (15) @(negedge clock);
   endtask
   task automatic do_reset();
      @(negedge clock);
      rst_n = 1'b0;
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      n_reload = 0;
      n_start = 0;
      repeat (4) @(negedge clock);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      fails = 0;
      checked = 0;
      power_good_live = 5'h1b;
      ext_clock_ok_live = 1'b1;
      clock_select_live = 1'b0;
      {thermal_shutdown_live, thermal_warning_live, input_undervoltage_live,
       overcurrent_live} = 8'h00;
      do_reset();
      rd_chk(pfmr_pkg::ADDR_POWER_CLOCK_MASK, 8'hff, "mask1 reset");
      rd_chk(pfmr_pkg::ADDR_FAULT_MASK, 8'hff, "mask2 reset");
      rd_chk(pfmr_pkg::ADDR_RESET_CONTROL, 8'h10, "control reset");
      rd_chk(8'h31, pfmr_pkg::PRODUCT_CODE, "product code");
      rd_chk(8'h26, 8'h00, "unmapped");
      rd_chk(pfmr_pkg::ADDR_POWER_SENSE, 8'h5b, "power sense");
      host.start();
      host.send_byte(8'h22, ack);
      host.stop();
      check("foreign address ack", {7'h00, ack}, 8'h00);
      $display("test reset values done");
      // last pattern drops shutdown, which restarts under policy 00
      foreach (pats[i])
      begin
         set_sense(pats[i]);
         rd_chk(pfmr_pkg::ADDR_FAULT_SENSE, pats[i],
                "fault sense");
      end
      check("reload after exit", 8'(n_reload), 8'h01);
      $display("test live sense done");
      wr(pfmr_pkg::ADDR_FAULT_SENSE, 8'hff);
      wr(8'h31, 8'h00);
      rd_chk(pfmr_pkg::ADDR_FAULT_SENSE, 8'h00, "sense after write");
      rd_chk(8'h31, pfmr_pkg::PRODUCT_CODE, "code after write");
      wr(pfmr_pkg::ADDR_POWER_CLOCK_MASK, 8'h00);
      rd_chk(pfmr_pkg::ADDR_POWER_CLOCK_MASK, 8'h20, "mask1 spare");
      wr(pfmr_pkg::ADDR_FAULT_MASK, 8'h00);
      rd_chk(pfmr_pkg::ADDR_FAULT_MASK, 8'h00, "mask2 clear");
      $display("test masks done");
      wr(pfmr_pkg::ADDR_FAULT_MASK, 8'hff);
      host.read_reg(pfmr_pkg::ADDR_EVENT_LATCH1, rd, ack);
      host.read_reg(pfmr_pkg::ADDR_EVENT_LATCH2, rd, ack);
      set_sense(8'h01);
      check("irq masked", {7'h00, irq}, 8'h00);
      wr(pfmr_pkg::ADDR_FAULT_MASK, 8'hfe);
      check("irq unmasked", {7'h00, irq}, 8'h01);
      rd_chk(pfmr_pkg::ADDR_EVENT_LATCH2, 8'h01, "latched event");
      check("irq after read", {7'h00, irq}, 8'h00);
      rd_chk(pfmr_pkg::ADDR_EVENT_LATCH2, 8'h00, "latch cleared");
      set_sense(8'h00);
      $display("test interrupt done");
      // every recovery code, each from a fresh reset
      for (int c = 0; c < 4; c++)
      begin
         do_reset();
         wr(pfmr_pkg::ADDR_FAULT_MASK, 8'h3c);
         wr(pfmr_pkg::ADDR_RESET_CONTROL, 8'(c));
         set_sense(8'h80);
         set_sense(8'h00);
         check("reload", 8'(n_reload), {7'h00, c == 0});
         check("restart", 8'(n_start), {7'h00, c < 2});
         check("blocked", {7'h00, rearm_blocked}, {7'h00, c > 1});
         rd_chk(pfmr_pkg::ADDR_FAULT_MASK, (c == 0) ? 8'hff : 8'h3c,
                "mask2 after exit");
         rd_chk(pfmr_pkg::ADDR_RESET_CONTROL, (c == 0) ? 8'h10 : 8'(c),
                "control after exit");
      end
      $display("test thermal recovery done");
      wr(pfmr_pkg::ADDR_POWER_CLOCK_MASK, 8'h00);
      n_reload = 0;
      wr(pfmr_pkg::ADDR_RESET_CONTROL, 8'h81);
      check("forced reload", 8'(n_reload), 8'h01);
      rd_chk(pfmr_pkg::ADDR_POWER_CLOCK_MASK, 8'hff, "mask1 reload");
      rd_chk(pfmr_pkg::ADDR_RESET_CONTROL, 8'h10, "control reload");
      $display("test forced reload done");
      give_verdict();
   end
   // the run needs about 31k cycles; stop well beyond that
   initial
   begin
      #400000;
      fails++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule
